// *** pkg/sjs_pkg.sv ***
// Package of constants and types for the short jump and subtract execution block
package sjs_pkg;
  localparam int unsigned PC_W           = 16;        // Program counter width
  localparam int unsigned DATA_W         = 8;         // Accumulator and operand width
  localparam logic [15:0] PC_ADVANCE     = 16'h0002;  // Jump instruction length in bytes
  localparam logic [15:0] PC_RST         = 16'h0000;  // Program counter after reset
  localparam logic [7:0]  ACC_RST        = 8'h00;     // Accumulator after reset
  localparam logic        FLAG_RST       = 1'b0;      // Every flag after reset
  localparam int unsigned NIB_MSB        = 3;         // Top bit of the lower nibble
  localparam int unsigned BIT6_POS       = 6;         // Next-to-top bit position
  localparam int unsigned BIT7_POS       = 7;         // Top bit position
  localparam int          JUMP_BACK_MAX  = 128;       // Farthest reach before the jump
  localparam int          JUMP_FWD_MAX   = 127;       // Farthest reach after the jump

  // Source operand choice of the subtract
  typedef enum logic [3:0] {
    SJS_SRC_REG  = 4'h1,  // Working register
    SJS_SRC_DIR  = 4'h2,  // Direct address
    SJS_SRC_IND  = 4'h4,  // Register-indirect address
    SJS_SRC_IMM  = 4'h8   // Immediate byte
  } sjs_src_t;

  // One-hot execution state
  typedef enum logic [2:0] {
    SJS_ST_IDLE  = 3'h1,  // Waiting for an instruction
    SJS_ST_JUMP  = 3'h2,  // Jump result being presented
    SJS_ST_SUB   = 3'h4   // Subtract result being presented
  } sjs_state_t;
endpackage : sjs_pkg

// *** sim/sjs_exec_tb.sv ***
// Self-checking testbench for the short jump and subtract execution unit
`timescale 1ns/1ps
module sjs_exec_tb;
  import sjs_pkg::*;
  logic        clk;            // Core clock
  logic        nrst;           // Reset, active low
  logic        jg;             // Jump request
  logic        sg;             // Subtract request
  logic [7:0]  disp;           // Jump displacement
  logic [3:0]  mode;           // Source mode
  logic [7:0]  rv, dv, iv, mv; // Candidate operands
  logic [15:0] pc;             // Program counter out
  logic [7:0]  acc;            // Accumulator out
  logic        cy, ac, ov, dn; // Flags and done
  logic [15:0] e_pc;           // Expected program counter
  logic [7:0]  e_acc;          // Expected accumulator
  logic        e_cy, e_ac;     // Expected carry and aux carry
  logic        e_ov, e_dn;     // Expected overflow and done
  int          mismatches;     // Failed comparisons
  int          samples_checked; // All comparisons

  sjs_exec dut (.I_MCLK(clk), .I_NRST(nrst), .i_jump_go(jg), .i_jump_disp(disp), .i_sub_go(sg),
    .i_sub_mode(mode), .i_reg_val(rv), .i_dir_val(dv), .i_ind_val(iv), .i_imm_val(mv),
    .O_PC(pc), .O_ACC(acc), .O_CARRY(cy), .O_AUX_CARRY(ac), .O_OVERFLOW(ov), .O_DONE(dn));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compare one value and count it
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Drive one cycle of requests, then 1 ns later judge what that same edge produced
  task automatic drv(input logic j, input logic s, input logic [7:0] d, input logic [3:0] m, input logic [7:0] v);
    logic [8:0] f;
    logic [4:0] l;
    logic [7:0] b7;
    logic [7:0] op;
    @(posedge clk);
    jg <= j;
    sg <= s;
    disp <= d;
    mode <= m;
    // Unchosen sources carry the inverse, so a wrong selection shows
    rv <= (m == SJS_SRC_REG) ? v : ~v;
    dv <= (m == SJS_SRC_DIR) ? v : ~v;
    iv <= (m == SJS_SRC_IND) ? v : ~v;
    mv <= (m == SJS_SRC_IMM) ? v : ~v;
    #1;
    chk(pc, e_pc);
    chk({8'h00, acc}, {8'h00, e_acc});
    chk({15'h0, cy}, {15'h0, e_cy});
    chk({15'h0, ac}, {15'h0, e_ac});
    chk({15'h0, ov}, {15'h0, e_ov});
    chk({15'h0, dn}, {15'h0, e_dn});
    e_dn = j | s;
    if (j) begin
      e_pc = e_pc + PC_ADVANCE + {{8{d[7]}}, d};
    end else if (s) begin
      // Invalid mode codes subtract zero
      op = (m == SJS_SRC_REG || m == SJS_SRC_DIR || m == SJS_SRC_IND || m == SJS_SRC_IMM) ? v : 8'h00;
      f = {1'b0, e_acc} - {1'b0, op} - {8'h00, e_cy};
      l = {1'b0, e_acc[3:0]} - {1'b0, op[3:0]} - {4'h0, e_cy};
      b7 = {1'b0, e_acc[6:0]} - {1'b0, op[6:0]} - {7'h00, e_cy};
      e_ov = b7[7] ^ f[8];
      e_cy = f[8];
      e_ac = l[4];
      e_acc = f[7:0];
    end
  endtask

  // Jumps back to back: plain, self loop, farthest back, farthest forward, with a subtract beside it
  task automatic t_jump();
    drv(1'b1, 1'b0, 8'h21, 4'h0, 8'h00);
    drv(1'b1, 1'b0, 8'hfe, 4'h0, 8'h00);
    drv(1'b1, 1'b0, 8'h80, 4'h0, 8'h00);
    drv(1'b1, 1'b0, 8'h7f, 4'h0, 8'h00);
    drv(1'b1, 1'b1, 8'h05, SJS_SRC_IMM, 8'h11);
    drv(1'b0, 1'b0, 8'h00, 4'h0, 8'h00);
  endtask

  // Subtract chain through every source mode; borrow carries from step to step
  task automatic t_sub();
    drv(1'b0, 1'b1, 8'h00, SJS_SRC_IMM, 8'h37);
    drv(1'b0, 1'b1, 8'h00, SJS_SRC_REG, 8'h54);
    drv(1'b0, 1'b1, 8'h00, SJS_SRC_DIR, 8'hf0);
    drv(1'b0, 1'b1, 8'h00, SJS_SRC_IND, 8'h7f);
    drv(1'b0, 1'b1, 8'h00, 4'h3, 8'h5a);
    drv(1'b0, 1'b0, 8'h00, 4'h0, 8'h00);
    drv(1'b0, 1'b1, 8'h00, SJS_SRC_IMM, 8'h80);
    drv(1'b0, 1'b0, 8'h00, 4'h0, 8'h00);
    drv(1'b0, 1'b0, 8'h00, 4'h0, 8'h00);
  endtask

  // Single place where the run ends
  task automatic finish_test();
    $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Reset for three cycles, then the scenarios
  initial begin
    mismatches = 0;
    samples_checked = 0;
    nrst = 1'b0;
    jg = 1'b0;
    sg = 1'b0;
    disp = 8'h00;
    mode = 4'h0;
    rv = 8'h00;
    dv = 8'h00;
    iv = 8'h00;
    mv = 8'h00;
    e_pc = PC_RST;
    e_acc = ACC_RST;
    e_cy = FLAG_RST;
    e_ac = FLAG_RST;
    e_ov = FLAG_RST;
    e_dn = 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_jump();
    t_sub();
    finish_test();
  end
endmodule // sjs_exec_tb

// *** verilog/sjs_exec.sv ***
// Execution unit for the short relative jump and the subtract with borrow
`timescale 1ns/1ps
module sjs_exec
  import sjs_pkg::*;
(
  input  wire logic        I_MCLK,         // Core clock
  input  wire logic        I_NRST,         // Asynchronous reset, active low
  input  wire logic        i_jump_go,      // Pulse: execute short jump
  input  wire logic [7:0]  i_jump_disp,    // Second instruction byte
  input  wire logic        i_sub_go,       // Pulse: execute subtract with borrow
  input  wire logic [3:0]  i_sub_mode,     // One-hot source addressing mode
  input  wire logic [7:0]  i_reg_val,      // Working register value
  input  wire logic [7:0]  i_dir_val,      // Byte read at direct address
  input  wire logic [7:0]  i_ind_val,      // Byte read through register pointer
  input  wire logic [7:0]  i_imm_val,      // Immediate byte
  output logic      [15:0] O_PC,           // Program counter
  output logic      [7:0]  O_ACC,          // Accumulator
  output logic             O_CARRY,        // Carry / borrow flag
  output logic             O_AUX_CARRY,    // Auxiliary carry flag
  output logic             O_OVERFLOW,     // Overflow flag
  output logic             O_DONE          // Pulse: result updated
);
  // Whole state of the unit
  typedef struct packed {
    sjs_state_t  st;      // Execution state
    logic [15:0] pc;      // Program counter
    logic [7:0]  acc;     // Accumulator
    logic        cy;      // Carry
    logic        ac;      // Auxiliary carry
    logic        ov;      // Overflow
    logic        done;    // Completion pulse
  } sjs_regs_t;

  sjs_regs_t s_r;    // Registered state
  sjs_regs_t s_nxt;  // Next state

  logic [7:0] src_byte;   // Selected subtrahend
  logic [7:0] diff;       // Arithmetic result
  logic       cy_out;     // New carry
  logic       ac_out;     // New auxiliary carry
  logic       ov_out;     // New overflow

  // Sign-extend a displacement; shared by the jump path and its check
  function automatic logic [15:0] sext_disp(input logic [7:0] d);
    sext_disp = {{8{d[7]}}, d};
  endfunction

  // Operand select; an unknown mode code reads as zero so no stale byte slips in
  always_comb begin
    case (i_sub_mode)
      SJS_SRC_REG: src_byte = i_reg_val;
      SJS_SRC_DIR: src_byte = i_dir_val;
      SJS_SRC_IND: src_byte = i_ind_val;
      SJS_SRC_IMM: src_byte = i_imm_val;
      default:     src_byte = 8'h00;
    endcase
  end

  // Arithmetic kept apart so the flags can be reused by other subtract forms
  sjs_sub_borrow u_sub (
    .i_acc   (s_r.acc),
    .i_src   (src_byte),
    .i_carry (s_r.cy),
    .o_diff  (diff),
    .o_carry (cy_out),
    .o_aux   (ac_out),
    .o_ovf   (ov_out)
  );

  // Next-state logic; jump wins if both strobes arrive together
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    s_nxt.st   = SJS_ST_IDLE;
    case (s_r.st)
      SJS_ST_IDLE, SJS_ST_JUMP, SJS_ST_SUB: begin
        if (i_jump_go) begin
          // Unconditional: no flag is looked at
          s_nxt.pc   = s_r.pc + PC_ADVANCE + sext_disp(i_jump_disp);
          s_nxt.st   = SJS_ST_JUMP;
          s_nxt.done = 1'b1;
        end else if (i_sub_go) begin
          s_nxt.acc  = diff;
          s_nxt.cy   = cy_out;
          s_nxt.ac   = ac_out;
          s_nxt.ov   = ov_out;
          s_nxt.st   = SJS_ST_SUB;
          s_nxt.done = 1'b1;
        end
      end
      default: begin
        s_nxt.st = SJS_ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      s_r.st   <= SJS_ST_IDLE;
      s_r.pc   <= PC_RST;
      s_r.acc  <= ACC_RST;
      s_r.cy   <= FLAG_RST;
      s_r.ac   <= FLAG_RST;
      s_r.ov   <= FLAG_RST;
      s_r.done <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state flops
  assign O_PC        = s_r.pc;
  assign O_ACC       = s_r.acc;
  assign O_CARRY     = s_r.cy;
  assign O_AUX_CARRY = s_r.ac;
  assign O_OVERFLOW  = s_r.ov;
  assign O_DONE      = s_r.done;

  // Jump checks
  // The old PC is only reachable in clocked context, so the reach check forms its distance
  // inside the property itself rather than in a helper net

  jump_always_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    i_jump_go |=> (O_DONE && s_r.st == SJS_ST_JUMP))
    else $error("jump request not taken");

  jump_target_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    i_jump_go |=> (O_PC == $past(O_PC) + PC_ADVANCE + sext_disp($past(i_jump_disp))))
    else $error("jump target wrong");

  // Distance is taken modulo the PC width, so a jump across address zero still counts as near
  jump_reach_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    i_jump_go |=> ($signed(16'(O_PC - $past(O_PC))) >= -JUMP_BACK_MAX &&
                   $signed(16'(O_PC - $past(O_PC))) <= JUMP_FWD_MAX + 2))
    else $error("jump outside reach");

  sext_disp_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    (i_jump_go && i_jump_disp == 8'hfe) |=> $stable(O_PC))
    else $error("self loop displacement moved pc");

  // Subtract checks: expectations rebuilt from plain arithmetic, not from the flag unit
  sub_result_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    (i_sub_go && !i_jump_go) |=>
      ({O_CARRY, O_ACC} == ({1'b0, $past(O_ACC)} - {1'b0, $past(src_byte)} - {8'h00, $past(O_CARRY)})))
    else $error("subtract result wrong");

  sub_carry_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    (i_sub_go && !i_jump_go) |=>
      (O_CARRY == ({1'b0, $past(O_ACC)} < ({1'b0, $past(src_byte)} + {8'h00, $past(O_CARRY)}))))
    else $error("borrow flag wrong");

  sub_aux_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    (i_sub_go && !i_jump_go) |=>
      (O_AUX_CARRY == ({1'b0, $past(O_ACC[3:0])} < ({1'b0, $past(src_byte[3:0])} + {4'h0, $past(O_CARRY)}))))
    else $error("auxiliary flag wrong");

  sub_ovf_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    (i_sub_go && !i_jump_go) |=>
      (O_OVERFLOW == (($past(O_ACC[7]) != $past(src_byte[7])) && (O_ACC[7] != $past(O_ACC[7])))))
    else $error("overflow flag wrong");

  src_select_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    (i_sub_mode == SJS_SRC_IMM) |-> (src_byte == i_imm_val))
    else $error("immediate source not chosen");

  flags_hold_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    i_jump_go |=> ($stable(O_ACC) && $stable(O_CARRY) &&
                   $stable(O_AUX_CARRY) && $stable(O_OVERFLOW)))
    else $error("jump disturbed arithmetic state");

  // Each source mode picks its own byte; an invalid mode code picks zero
  src_reg_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    (i_sub_mode == SJS_SRC_REG) |-> (src_byte == i_reg_val))
    else $error("register source not chosen");

  src_dir_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    (i_sub_mode == SJS_SRC_DIR) |-> (src_byte == i_dir_val))
    else $error("direct source not chosen");

  src_ind_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    (i_sub_mode == SJS_SRC_IND) |-> (src_byte == i_ind_val))
    else $error("indirect source not chosen");

  src_bad_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    !$onehot(i_sub_mode) |-> (src_byte == 8'h00))
    else $error("invalid mode did not give zero operand");

  // Bookkeeping: done pulse, state code, and what an instruction must leave alone
  sub_done_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    (i_sub_go && !i_jump_go) |=> (O_DONE && s_r.st == SJS_ST_SUB))
    else $error("subtract request not taken");

  jump_first_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    (i_jump_go && i_sub_go) |=> (s_r.st == SJS_ST_JUMP && $stable(O_ACC)))
    else $error("subtract beat a jump");

  sub_pc_hold_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    (i_sub_go && !i_jump_go) |=> $stable(O_PC))
    else $error("subtract moved pc");

  // With no request the unit must not drift: nothing else loads these registers
  idle_hold_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    (!i_jump_go && !i_sub_go) |=> (!O_DONE && $stable(O_PC) && $stable(O_ACC) &&
                                   $stable(O_CARRY) && $stable(O_AUX_CARRY) && $stable(O_OVERFLOW)))
    else $error("state changed without request");

  done_state_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    O_DONE == (s_r.st != SJS_ST_IDLE))
    else $error("done pulse out of step with state");

  // A corrupted state code would silently fall into the default branch
  state_onehot_a: assert property (@(posedge I_MCLK) disable iff (!I_NRST)
    $onehot(s_r.st))
    else $error("state code not one-hot");
endmodule // sjs_exec

// *** verilog/sjs_sub_borrow.sv ***
// Combinational subtract-with-borrow arithmetic and flag generation
`timescale 1ns/1ps
module sjs_sub_borrow
  import sjs_pkg::*;
(
  input  wire logic [7:0] i_acc,       // Minuend
  input  wire logic [7:0] i_src,       // Subtrahend
  input  wire logic       i_carry,     // Incoming borrow
  output logic      [7:0] o_diff,      // Difference
  output logic            o_carry,     // Borrow out of bit 7
  output logic            o_aux,       // Borrow out of bit 3
  output logic            o_ovf        // Signed overflow
);
  logic [4:0] low_sum;   // Low nibble with borrow
  logic [7:0] low7_sum;  // Bits 6:0 with borrow out in bit 7
  logic [8:0] full_sum;  // Full width with borrow in bit 8

  // Widened differences expose each borrow in their top bit
  always_comb begin
    low_sum  = {1'b0, i_acc[NIB_MSB:0]} - {1'b0, i_src[NIB_MSB:0]} - {4'h0, i_carry};
    low7_sum = {1'b0, i_acc[BIT6_POS:0]} - {1'b0, i_src[BIT6_POS:0]} - {7'h00, i_carry};
    full_sum = {1'b0, i_acc} - {1'b0, i_src} - {8'h00, i_carry};
    o_diff   = full_sum[7:0];
    o_carry  = full_sum[8];
    o_aux    = low_sum[4];
    // Borrow into bit 7 differs from borrow out of bit 7
    o_ovf    = low7_sum[BIT7_POS] ^ full_sum[8];
  end
endmodule // sjs_sub_borrow
